/* async_serial_regs.svh */
/*
 Constants for the asynchronous serial unit: start-bit sample point, oversampling
 and reset values. Assumes inclusion by bare name from the design.
*/
`ifndef ASYNC_SERIAL_REGS_SVH
`define ASYNC_SERIAL_REGS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define OVERSAMPLE 16
`define MID_SAMPLE 7
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RXD_RESET 8'h00
`define TX_EMPTY_RESET 1'b1
`define TX_END_RESET 1'b1
`endif

/* async_serial_pkg.sv */
/*
 Types for the asynchronous serial unit.
 Assumes nothing of its surroundings.
*/
package async_serial_pkg;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP} rx_state_t;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP1, TX_STOP2} tx_state_t;
endpackage : async_serial_pkg

/* serial_unit.sv */
/*
 Asynchronous serial unit: receiver with parity, framing and overrun
 checks, multiprocessor address filtering, and transmitter.
 Assumes a one-cycle tick at sixteen times the bit rate, inputs
 synchronous to clk, and software clear strobes as one-cycle pulses.
*/
`timescale 1ns/1ps
`include "async_serial_regs.svh"

// Operation
// RULE_01: Low start bit starts frame capture
// RULE_02: Data shifted in LSB first
// RULE_03: Parity mismatch flags error, data still stored
// RULE_04: First stop bit zero flags framing error
// RULE_05: Store only when full flag clear
// RULE_06: Full at frame end sets overrun
// RULE_07: Good frame sets full, stores byte
// RULE_08: Errors halt reception until cleared
// RULE_09: Full flag raises receive irq if enabled
// RULE_10: Any error with enable raises error irq
// RULE_11: Software clears error flags to resume
// RULE_12: Software clears full before stop bit
// RULE_13: Address flag bit marks ID frames
// RULE_14: Multiprocessor format has no parity
// RULE_15: Tx frame start data flag stop
// RULE_16: Empty clear loads shifter, sets empty
// RULE_17: Stop bit checks empty, chains or ends
// RULE_18: Software writes byte, flag, clears empty
// RULE_19: Address wait discards data frames
// RULE_20: Software compares ID, rearms address wait
// RULE_21: Software sets port before disabling tx
// RULE_22: Accepted ID frame clears address wait
// RULE_23: Tx disable sets empty; rx disable keeps
// RULE_24: External clock is sixteen times bit rate
module serial_unit
    import async_serial_pkg::*;
#(
    parameter int OVS = `OVERSAMPLE
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Bit clock, sixteen per bit
    input wire logic bit_tick,
    // Line
    input wire logic rxd,
    output logic txd,
    // Mode
    input wire logic seven_bit,
    input wire logic parity_en,
    input wire logic odd_parity_sel,
    input wire logic multiproc_en,
    input wire logic two_stop,
    // Control
    input wire logic rx_on,
    input wire logic transmit_enable,
    input wire logic rx_full_irq_en,
    input wire logic tx_empty_irq_en,
    input wire logic tx_end_irq_en,
    input wire logic addr_wait_set,
    input wire logic addr_flag_tx_bit,
    // Software clears, one-cycle pulses
    input wire logic rx_full_clr,
    input wire logic tx_empty_clr,
    input wire logic overrun_clr,
    input wire logic framing_clr,
    input wire logic parity_clr,
    // Transmit data
    input wire logic [7:0] transmit_data_register,
    // Status
    output logic [7:0] receive_data_register,
    output logic rx_full_flag,
    output logic overrun_error_flag,
    output logic framing_error_flag,
    output logic parity_error_flag,
    output logic addr_flag_bit,
    output logic addr_wait_en,
    output logic tx_empty_flag,
    output logic transmit_end_flag,
    // Interrupts
    output logic rx_full_irq,
    output logic rx_error_irq,
    output logic tx_empty_irq,
    output logic tx_end_irq
);

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    rx_state_t rx_state_r;
    logic [3:0] rx_os_r;
    logic [2:0] rx_bit_r;
    logic [7:0] receive_shift_register_r;
    logic rx_extra_r;
    logic rx_done;
    logic rx_sample;
    logic rx_errors;
    logic rx_store;
    logic rx_par_bad;
    logic rx_ovr;
    logic rx_drop;
    logic [2:0] last_bit;

    assign last_bit = seven_bit ? 3'h6 : 3'h7;
    assign rx_errors = overrun_error_flag | framing_error_flag | parity_error_flag;
    assign rx_sample = bit_tick && (rx_os_r == 4'(OVS - 1));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_state_r <= RX_IDLE;
            rx_os_r <= 4'h0;
            rx_bit_r <= 3'h0;
            receive_shift_register_r <= 8'h00;
            rx_extra_r <= 1'b0;
        end else if (!rx_on || rx_errors) begin
            rx_state_r <= RX_IDLE; // [RULE_08] [RULE_23]
            rx_os_r <= 4'h0;
        end else if (bit_tick) begin
            rx_os_r <= rx_os_r + 4'h1;
            unique case (rx_state_r)
                RX_IDLE: begin
                    rx_os_r <= 4'h0;
                    if (!rxd) begin
                        rx_state_r <= RX_START; // [RULE_01]
                    end
                end
                RX_START: begin
                    if (rx_os_r == 4'(`MID_SAMPLE)) begin
                        rx_os_r <= 4'h0;
                        rx_bit_r <= 3'h0;
                        receive_shift_register_r <= 8'h00;
                        rx_extra_r <= 1'b0;
                        rx_state_r <= rxd ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_sample) begin
                        rx_os_r <= 4'h0;
                        receive_shift_register_r[rx_bit_r] <= rxd; // [RULE_02]
                        rx_bit_r <= rx_bit_r + 3'h1;
                        if (rx_bit_r == last_bit) begin
                            rx_state_r <= (multiproc_en || parity_en) ? RX_EXTRA : RX_STOP;
                        end
                    end
                end
                RX_EXTRA: begin
                    if (rx_sample) begin
                        rx_os_r <= 4'h0;
                        rx_extra_r <= rxd;
                        rx_state_r <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_sample) begin
                        rx_os_r <= 4'h0;
                        rx_state_r <= RX_IDLE; // [RULE_04]
                    end
                end
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end

    assign rx_done = rx_on && !rx_errors && bit_tick && rx_sample && (rx_state_r == RX_STOP);
    assign rx_par_bad = !multiproc_en && parity_en
        && ((^receive_shift_register_r ^ rx_extra_r) != odd_parity_sel); // [RULE_03] [RULE_14]
    assign rx_drop = multiproc_en && addr_wait_en && !rx_extra_r; // [RULE_19]
    assign rx_ovr = rx_done && !rx_drop && rx_full_flag; // [RULE_06]
    assign rx_store = rx_done && !rx_drop && !rx_full_flag; // [RULE_05]

    // ----------------------------------------
    // Receive flags and data
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            receive_data_register <= `RXD_RESET;
            addr_flag_bit <= 1'b0;
        end else if (rx_store) begin
            receive_data_register <= receive_shift_register_r; // [RULE_03] [RULE_04]
            addr_flag_bit <= multiproc_en & rx_extra_r; // [RULE_13]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_full_flag <= 1'b0;
        end else if (rx_store && rxd && !rx_par_bad) begin
            rx_full_flag <= 1'b1; // [RULE_07]
        end else if (rx_full_clr) begin
            rx_full_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // Receive errors and address wait
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            overrun_error_flag <= 1'b0;
        end else if (rx_ovr) begin
            overrun_error_flag <= 1'b1; // [RULE_06]
        end else if (overrun_clr) begin
            overrun_error_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            framing_error_flag <= 1'b0;
        end else if (rx_store && !rxd) begin
            framing_error_flag <= 1'b1; // [RULE_04]
        end else if (framing_clr) begin
            framing_error_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            parity_error_flag <= 1'b0;
        end else if (rx_store && rx_par_bad) begin
            parity_error_flag <= 1'b1; // [RULE_03]
        end else if (parity_clr) begin
            parity_error_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_wait_en <= 1'b0;
        end else if (rx_store && multiproc_en && rx_extra_r) begin
            addr_wait_en <= 1'b0; // [RULE_22]
        end else if (addr_wait_set) begin
            addr_wait_en <= 1'b1;
        end
    end

    // ----------------------------------------
    // Receive interrupts
    // ----------------------------------------
    assign rx_full_irq = rx_full_flag & rx_full_irq_en; // [RULE_09]
    assign rx_error_irq = rx_errors & rx_full_irq_en; // [RULE_10]

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    tx_state_t tx_state_r;
    logic [3:0] tx_os_r;
    logic [2:0] tx_bit_r;
    logic [7:0] transmit_shift_register_r;
    logic tx_mpb_r;
    logic tx_load;
    logic tx_bit_end;
    logic tx_stop_last;

    assign tx_bit_end = bit_tick && (tx_os_r == 4'(OVS - 1));
    assign tx_stop_last = tx_bit_end
        && ((tx_state_r == TX_STOP2) || (tx_state_r == TX_STOP1 && !two_stop));
    assign tx_load = transmit_enable && !tx_empty_flag
        && ((tx_state_r == TX_IDLE) || tx_stop_last); // [RULE_16] [RULE_17]

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_state_r <= TX_IDLE;
            tx_os_r <= 4'h0;
            tx_bit_r <= 3'h0;
            transmit_shift_register_r <= 8'h00;
            tx_mpb_r <= 1'b0;
        end else if (!transmit_enable) begin
            tx_state_r <= TX_IDLE; // [RULE_23]
            tx_os_r <= 4'h0;
            transmit_shift_register_r <= 8'h00;
        end else if (tx_load) begin
            transmit_shift_register_r <= transmit_data_register;
            tx_mpb_r <= addr_flag_tx_bit; // [RULE_15]
            tx_bit_r <= 3'h0;
            tx_os_r <= 4'h0;
            tx_state_r <= TX_START;
        end else if (bit_tick && tx_state_r != TX_IDLE) begin
            tx_os_r <= tx_os_r + 4'h1;
            if (tx_bit_end) begin
                tx_os_r <= 4'h0;
                unique case (tx_state_r)
                    TX_START: tx_state_r <= TX_DATA;
                    TX_DATA: begin
                        tx_bit_r <= tx_bit_r + 3'h1;
                        if (tx_bit_r == last_bit) begin
                            tx_state_r <= (multiproc_en || parity_en) ? TX_EXTRA : TX_STOP1;
                        end
                    end
                    TX_EXTRA: tx_state_r <= TX_STOP1;
                    TX_STOP1: tx_state_r <= two_stop ? TX_STOP2 : TX_IDLE;
                    TX_STOP2: tx_state_r <= TX_IDLE;
                    default: tx_state_r <= TX_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Line output, registered
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            txd <= 1'b1;
        end else begin
            unique case (tx_state_r)
                TX_START: txd <= 1'b0;
                TX_DATA: txd <= transmit_shift_register_r[tx_bit_r]; // [RULE_15]
                TX_EXTRA: txd <= multiproc_en ? tx_mpb_r
                    : (^transmit_shift_register_r[6:0]
                    ^ (!seven_bit & transmit_shift_register_r[7]) ^ odd_parity_sel); // [RULE_14]
                default: txd <= 1'b1;
            endcase
        end
    end

    // ----------------------------------------
    // Transmit flags
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_empty_flag <= `TX_EMPTY_RESET;
        end else if (!transmit_enable || tx_load) begin
            tx_empty_flag <= 1'b1; // [RULE_16] [RULE_23]
        end else if (tx_empty_clr) begin
            tx_empty_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            transmit_end_flag <= `TX_END_RESET;
        end else if (tx_stop_last && tx_empty_flag) begin
            transmit_end_flag <= 1'b1; // [RULE_17]
        end else if (tx_load) begin
            transmit_end_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // Transmit interrupts
    // ----------------------------------------
    assign tx_empty_irq = tx_empty_flag & tx_empty_irq_en & transmit_enable; // [RULE_16]
    assign tx_end_irq = transmit_end_flag & tx_end_irq_en & transmit_enable; // [RULE_17]

endmodule : serial_unit

/* serial_unit_asserts.sv */
/*
 Checker for the serial unit port behaviour.
 Assumes a bind to serial_unit from the bench top file.
*/
`timescale 1ns/1ps
// ----------------------------------------
// Checker
// ----------------------------------------
module serial_unit_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Watched ports
    input wire logic txd,
    input wire logic transmit_enable,
    input wire logic rx_full_irq_en,
    input wire logic tx_end_irq_en,
    input wire logic [7:0] receive_data_register,
    input wire logic rx_full_flag,
    input wire logic overrun_error_flag,
    input wire logic framing_error_flag,
    input wire logic parity_error_flag,
    input wire logic tx_empty_flag,
    input wire logic transmit_end_flag,
    input wire logic rx_full_irq,
    input wire logic rx_error_irq,
    input wire logic tx_end_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic any_err;
    assign any_err = overrun_error_flag | framing_error_flag | parity_error_flag;
    a_full_irq_level: assert property (rx_full_irq == (rx_full_flag && rx_full_irq_en))
        else $error("receive irq mismatch");
    a_err_irq_level: assert property (rx_error_irq == (any_err && rx_full_irq_en))
        else $error("error irq mismatch");
    a_overrun_keeps_data: assert property ($rose(overrun_error_flag) |->
        $past(rx_full_flag) && $stable(receive_data_register))
        else $error("overrun without full or data changed");
    a_error_halts_rx: assert property (any_err |=> !$rose(rx_full_flag))
        else $error("full set while error pending");
    a_bad_frame_nofull: assert property ($rose(framing_error_flag) || $rose(parity_error_flag)
        |-> !$rose(rx_full_flag))
        else $error("full set on bad frame");
    a_tx_off_empty: assert property (!transmit_enable ##1 !transmit_enable |-> tx_empty_flag)
        else $error("empty flag low while tx disabled");
    a_load_starts: assert property (transmit_enable && transmit_end_flag &&
        $fell(tx_empty_flag) |-> ##2 (tx_empty_flag && !txd))
        else $error("load did not start frame");
    a_mark_idle: assert property (transmit_end_flag && $past(transmit_end_flag) &&
        $past(tx_empty_flag) |-> txd)
        else $error("line not marking when idle");
    a_end_irq_level: assert property (tx_end_irq ==
        (transmit_end_flag && tx_end_irq_en && transmit_enable))
        else $error("end irq mismatch");
endmodule : serial_unit_checker

/* remote_node.sv */
/*
 Remote serial node driving the receive line.
 Assumes calls from the bench just after a rising clock edge.
*/
`timescale 1ns/1ps
// ----------------------------------------
// Remote node
// ----------------------------------------
module remote_node #(
    parameter int OVS = 16
) (
    // Clock
    input wire logic clk,
    // Line
    output logic rxd
);
    initial rxd = 1'b1;
    task automatic put_bit(input logic b);
        rxd = b;
        repeat (OVS) @(posedge clk);
        #1;
    endtask : put_bit
    // Start, data LSB first, optional extra bit, stop, idle
    task automatic send(input logic [7:0] d, input int nbits, input logic x, input logic has_x,
        input logic stopv);
        put_bit(1'b0);
        for (int i = 0; i < nbits; i++) put_bit(d[i]);
        if (has_x) put_bit(x);
        put_bit(stopv);
        put_bit(1'b1);
    endtask : send
endmodule : remote_node

/* async_serial_rx_multiproc_tb.sv */
/*
 Self-checking bench for the serial unit.
 Assumes the checker and remote node files compiled before it.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
// ----------------------------------------
// Bench top
// ----------------------------------------
module async_serial_rx_multiproc_tb;
    logic clk, arst_n, bit_tick, rxd, txd, seven_bit, parity_en, odd_parity_sel, multiproc_en;
    logic two_stop, rx_on, transmit_enable, rx_full_irq_en, tx_empty_irq_en, tx_end_irq_en;
    logic addr_flag_tx_bit, rx_full_flag, overrun_error_flag, framing_error_flag;
    logic parity_error_flag, addr_flag_bit, addr_wait_en, tx_empty_flag, transmit_end_flag;
    logic rx_full_irq, rx_error_irq, tx_empty_irq, tx_end_irq;
    logic [5:0] clr;
    logic [7:0] transmit_data_register, receive_data_register;
    int failures, check_count, cyc;
    serial_unit #(.OVS(16)) serial_unit_inst (.clk, .arst_n, .bit_tick, .rxd, .txd, .seven_bit,
        .parity_en, .odd_parity_sel, .multiproc_en, .two_stop, .rx_on, .transmit_enable,
        .rx_full_irq_en, .tx_empty_irq_en, .tx_end_irq_en, .addr_wait_set(clr[5]),
        .addr_flag_tx_bit, .rx_full_clr(clr[0]), .tx_empty_clr(clr[1]), .overrun_clr(clr[2]),
        .framing_clr(clr[3]), .parity_clr(clr[4]), .transmit_data_register,
        .receive_data_register, .rx_full_flag, .overrun_error_flag, .framing_error_flag,
        .parity_error_flag, .addr_flag_bit, .addr_wait_en, .tx_empty_flag, .transmit_end_flag,
        .rx_full_irq, .rx_error_irq, .tx_empty_irq, .tx_end_irq);
    remote_node #(.OVS(16)) remote_node_inst (.clk, .rxd);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict
    task automatic pulse(input int i);
        clr[i] = 1'b1;
        @(posedge clk);
        #1;
        clr[i] = 1'b0;
    endtask : pulse
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_receive();
        remote_node_inst.send(8'hA5, 8, 1'b0, 1'b0, 1'b1);
        `CHK(rx_full_flag, 1'b1)
        `CHK(receive_data_register, 8'hA5)
        `CHK(rx_full_irq, 1'b1)
        pulse(0);
        seven_bit = 1'b1;
        remote_node_inst.send(8'hD3, 7, 1'b0, 1'b0, 1'b1);
        `CHK(receive_data_register, 8'h53)
        pulse(0);
        seven_bit = 1'b0;
    endtask : s_receive
    task automatic s_errors();
        parity_en = 1'b1;
        remote_node_inst.send(8'h3C, 8, 1'b1, 1'b1, 1'b1);
        `CHK(parity_error_flag, 1'b1)
        `CHK(receive_data_register, 8'h3C)
        `CHK(rx_error_irq, 1'b1)
        remote_node_inst.send(8'h11, 8, 1'b0, 1'b1, 1'b1);
        `CHK({rx_full_flag, receive_data_register}, 9'h03C)
        pulse(4);
        odd_parity_sel = 1'b1;
        remote_node_inst.send(8'h3C, 8, 1'b1, 1'b1, 1'b1);
        `CHK({rx_full_flag, parity_error_flag}, 2'h2)
        pulse(0);
        parity_en = 1'b0;
        remote_node_inst.send(8'h5A, 8, 1'b0, 1'b0, 1'b0);
        `CHK({rx_full_flag, framing_error_flag, receive_data_register}, 10'h15A)
        pulse(3);
        remote_node_inst.send(8'h81, 8, 1'b0, 1'b0, 1'b1);
        remote_node_inst.send(8'h7E, 8, 1'b0, 1'b0, 1'b1);
        `CHK({overrun_error_flag, receive_data_register}, 9'h181)
        pulse(2);
        pulse(0);
    endtask : s_errors
    task automatic s_multi();
        multiproc_en = 1'b1;
        parity_en = 1'b1;
        pulse(5);
        `CHK(addr_wait_en, 1'b1)
        remote_node_inst.send(8'h22, 8, 1'b0, 1'b1, 1'b1);
        `CHK(rx_full_flag, 1'b0)
        remote_node_inst.send(8'h07, 8, 1'b1, 1'b1, 1'b1);
        `CHK({rx_full_flag, addr_flag_bit, receive_data_register}, 10'h307)
        `CHK(addr_wait_en, 1'b0)
        pulse(0);
        remote_node_inst.send(8'hAA, 8, 1'b0, 1'b1, 1'b1);
        `CHK({rx_full_flag, addr_flag_bit, receive_data_register}, 10'h2AA)
        rx_on = 1'b0;
        idle(2);
        `CHK({rx_full_flag, receive_data_register}, 9'h1AA)
        rx_on = 1'b1;
        pulse(0);
        pulse(5);
        remote_node_inst.send(8'h55, 8, 1'b0, 1'b1, 1'b1);
        `CHK({rx_full_flag, addr_wait_en, receive_data_register}, 10'h1AA)
    endtask : s_multi
    task automatic s_transmit();
        int n;
        logic [10:0] bits;
        transmit_data_register = 8'hC6;
        addr_flag_tx_bit = 1'b1;
        bits = {1'b1, 1'b1, 8'hC6, 1'b0};
        pulse(1);
        for (n = 0; n < 40 && txd; n++) idle(1);
        `CHK({tx_empty_flag, tx_empty_irq}, 2'h3)
        idle(8);
        for (n = 0; n < 11; n++) begin
            `CHK(txd, bits[n])
            idle(16);
        end
        `CHK({transmit_end_flag, tx_end_irq}, 2'h3)
        transmit_data_register = 8'h0F;
        addr_flag_tx_bit = 1'b0;
        pulse(1);
        idle(30);
        transmit_enable = 1'b0;
        idle(2);
        `CHK({tx_empty_flag, txd}, 2'h3)
        transmit_enable = 1'b1;
    endtask : s_transmit
    task automatic s_tx_chain();
        int n;
        logic [11:0] bits;
        multiproc_en = 1'b0;
        parity_en = 1'b1;
        odd_parity_sel = 1'b1;
        two_stop = 1'b1;
        seven_bit = 1'b1;
        transmit_data_register = 8'h35;
        bits = {1'b0, 3'h7, 7'h35, 1'b0};
        pulse(1);
        for (n = 0; n < 40 && txd; n++) idle(1);
        `CHK(tx_empty_flag, 1'b1)
        transmit_data_register = 8'h2A;
        pulse(1);
        idle(7);
        for (n = 0; n < 12; n++) begin
            `CHK(txd, bits[n])
            idle(16);
        end
        `CHK({transmit_end_flag, tx_empty_flag}, 2'h1)
        idle(160);
        `CHK(transmit_end_flag, 1'b1)
        {seven_bit, parity_en, two_stop} = 3'h0;
    endtask : s_tx_chain
    initial begin
        {arst_n, clr, seven_bit, parity_en, odd_parity_sel, multiproc_en, two_stop} = '0;
        {addr_flag_tx_bit, transmit_data_register, failures, check_count, cyc} = '0;
        {bit_tick, rx_on, transmit_enable} = 3'h7;
        {rx_full_irq_en, tx_empty_irq_en, tx_end_irq_en} = 3'h7;
        repeat (3) @(posedge clk);
        #1;
        arst_n = 1'b1;
        `CHK({tx_empty_flag, transmit_end_flag, txd, rx_full_flag}, 4'hE)
        s_receive();
        s_errors();
        s_multi();
        s_transmit();
        s_tx_chain();
        print_verdict();
    end
endmodule : async_serial_rx_multiproc_tb
bind serial_unit serial_unit_checker chk_inst (.clk, .arst_n, .txd, .transmit_enable,
    .rx_full_irq_en, .tx_end_irq_en, .receive_data_register, .rx_full_flag, .overrun_error_flag,
    .framing_error_flag, .parity_error_flag, .tx_empty_flag, .transmit_end_flag, .rx_full_irq,
    .rx_error_irq, .tx_end_irq);
